//--- rtl/adsq_params.svh
// Function
// - reset and standby clear control/status to zero
// - end flag cleared by zero after read
// - interrupt-started dma access clears end flag
// - flag set after single or full scan
// - interrupt while end flag and enable set
// - start bit high while converting, writable
// - single mode converts once then stops
// - scan repeats until start bit cleared
// - bit four picks single or scan
// - bit three picks long or short conversion
// - group bit plus channel offset field
// - reset and standby set trigger register 7F
// - trigger register low bits read one
// - enabled trigger pin falling edge starts
// - upper byte read loads low byte latch
// - ten bit successive approximation result
// - single end stores result, flags, stops
// - start write uses settings written together
// - result split eight high two low
// - channels n and n+4 share register
// - scan begins group start, chains immediately
// - reset and standby clear result registers
`ifndef ADSQ_PARAMS_SVH
`define ADSQ_PARAMS_SVH

// ----------------------------------------------------------------
// bus map
// ----------------------------------------------------------------
`define ADSQ_AW 4
`define ADSQ_OFS_RES_LAST 4'h7
`define ADSQ_OFS_CSR 4'h8
`define ADSQ_OFS_TCR 4'h9
`define ADSQ_LO_BYTE_BIT 0
`define ADSQ_RES_IDX_HI 2
`define ADSQ_RES_IDX_LO 1

// ----------------------------------------------------------------
// register layout and reset values
// ----------------------------------------------------------------
`define ADSQ_CSR_RST 8'h00
`define ADSQ_TCR_RST 8'h7F
`define ADSQ_TCR_EN 7
`define ADSQ_TCR_ONES 7'h7F
`define ADSQ_RES_W 10
`define ADSQ_RES_LO_PAD 6'h00

// ----------------------------------------------------------------
// conversion budget in states (266 and 134)
// ----------------------------------------------------------------
`define ADSQ_STATES_SLOW 9'h10A
`define ADSQ_STATES_FAST 9'h086

`endif

//--- rtl/adsq_pkg.sv
`default_nettype none
`include "adsq_params.svh"

package adsq_pkg;

    typedef enum logic [2:0] {
        ADSQ_SEQ_IDLE = 3'h1,
        ADSQ_SEQ_ISSUE = 3'h2,
        ADSQ_SEQ_WAIT = 3'h4
    } adsq_seq_e;

    typedef struct packed {
        logic sel;
        logic rd;
        logic wr;
        logic dma;
        logic [`ADSQ_AW-1:0] addr;
        logic [7:0] wdata;
    } adsq_bus_req_s;

    typedef struct packed {
        logic start;
        logic [2:0] channel;
        logic [8:0] states;
    } adsq_core_req_s;

    typedef struct packed {
        logic done;
        logic [`ADSQ_RES_W-1:0] result;
    } adsq_core_rsp_s;

    typedef struct packed {
        logic end_flag;
        logic irq_en;
        logic start;
        logic scan;
        logic time_sel;
        logic grp;
        logic [1:0] chan;
    } adsq_csr_s;

    typedef struct packed {
        adsq_csr_s csr;
        logic trg_en;
        logic flag_seen;
        adsq_seq_e seq;
        logic [1:0] cur_off;
        logic [7:0] rdata;
    } adsq_ctl_state_s;

    typedef struct packed {
        logic [3:0][`ADSQ_RES_W-1:0] res;
        logic [7:0] latch;
    } adsq_res_state_s;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } adsq_trig_state_s;

endpackage

`default_nettype wire

//--- rtl/adsq_trig.sv
`timescale 1ns/100ps
`default_nettype none

module adsq_trig (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // trigger pin, active low
    input wire logic ext_trigger_pin_n,
    // one-cycle falling edge pulse
    output logic fall
);

    adsq_pkg::adsq_trig_state_s st_ff;
    adsq_pkg::adsq_trig_state_s nxt_st;

    // s1 feeds only s2; edge is judged on s2 and s3
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.s1 = ext_trigger_pin_n;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
    end

    // idle high after reset so release gives no false edge
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            st_ff <= 3'h7;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign fall = st_ff.s3 && !st_ff.s2;

endmodule

`default_nettype wire

//--- rtl/adsq_res.sv
`timescale 1ns/100ps
`default_nettype none
`include "adsq_params.svh"

module adsq_res (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clear,
    // result store from sequencer
    input wire logic wr_en,
    input wire logic [1:0] wr_idx,
    input wire logic [`ADSQ_RES_W-1:0] wr_data,
    // cpu read side
    input wire logic rd_hi,
    input wire logic [1:0] rd_idx,
    output logic [7:0] hi_byte,
    output logic [7:0] latch
);

    adsq_pkg::adsq_res_state_s st_ff;
    adsq_pkg::adsq_res_state_s nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        for (int i = 0; i < 4; i++)
        begin
            if (wr_en && wr_idx == i[1:0])
            begin
                nxt_st.res[i] = wr_data;
            end
        end
        // latch takes the pre-write value so a word read stays coherent
        if (rd_hi)
        begin
            nxt_st.latch = {st_ff.res[rd_idx][1:0], `ADSQ_RES_LO_PAD};
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n || clear)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign hi_byte = st_ff.res[rd_idx][`ADSQ_RES_W-1:2];
    assign latch = st_ff.latch;

endmodule

`default_nettype wire

//--- rtl/adsq_ctl.sv
`timescale 1ns/100ps
`default_nettype none
`include "adsq_params.svh"

module adsq_ctl (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // power state
    input wire logic standby,
    // cpu and dma register bus
    input wire adsq_pkg::adsq_bus_req_s bus_req,
    output logic [7:0] bus_rdata,
    // external trigger pin, active low
    input wire logic ext_trigger_pin_n,
    // analog conversion core
    output adsq_pkg::adsq_core_req_s core_req,
    input wire adsq_pkg::adsq_core_rsp_s core_rsp,
    // interrupt request
    output logic conv_done_irq
);

    // ----------------------------------------------------------------
    // state and local signals
    // ----------------------------------------------------------------
    localparam logic [7:0] CSR_RST = `ADSQ_CSR_RST;
    localparam logic [7:0] TCR_RST = `ADSQ_TCR_RST;

    adsq_pkg::adsq_ctl_state_s st_ff;
    adsq_pkg::adsq_ctl_state_s nxt_st;
    adsq_pkg::adsq_csr_s wcsr;

    logic acc_res;
    logic acc_csr;
    logic acc_tcr;
    logic wr_csr;
    logic rd_hi;
    logic trg_fall;
    logic launch;
    logic set_flag;
    logic clr_flag;
    logic res_wr;
    logic [1:0] rd_idx;
    logic [7:0] hi_byte;
    logic [7:0] latch;
    logic [7:0] rd_mux;

    // ----------------------------------------------------------------
    // submodules
    // ----------------------------------------------------------------
    adsq_trig u_trig (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .ext_trigger_pin_n(ext_trigger_pin_n),
        .fall(trg_fall)
    );

    adsq_res u_res (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .clear(standby),
        .wr_en(res_wr),
        .wr_idx(st_ff.cur_off),
        .wr_data(core_rsp.result),
        .rd_hi(rd_hi),
        .rd_idx(rd_idx),
        .hi_byte(hi_byte),
        .latch(latch)
    );

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    assign acc_res = bus_req.sel && bus_req.addr <= `ADSQ_OFS_RES_LAST;
    assign acc_csr = bus_req.sel && bus_req.addr == `ADSQ_OFS_CSR;
    assign acc_tcr = bus_req.sel && bus_req.addr == `ADSQ_OFS_TCR;
    assign wr_csr = acc_csr && bus_req.wr;
    assign rd_idx = bus_req.addr[`ADSQ_RES_IDX_HI:`ADSQ_RES_IDX_LO];
    assign rd_hi = acc_res && bus_req.rd
        && !bus_req.addr[`ADSQ_LO_BYTE_BIT];

    always_comb
    begin
        if (acc_res)
        begin
            if (bus_req.addr[`ADSQ_LO_BYTE_BIT])
            begin
                rd_mux = latch;
            end
            else
            begin
                rd_mux = hi_byte;
            end
        end
        else if (acc_csr)
        begin
            rd_mux = st_ff.csr;
        end
        else if (acc_tcr)
        begin
            rd_mux = {st_ff.trg_en, `ADSQ_TCR_ONES};
        end
        else
        begin
            rd_mux = 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        wcsr = adsq_pkg::adsq_csr_s'(bus_req.wdata);
        nxt_st = st_ff;
        res_wr = 1'h0;
        set_flag = 1'h0;
        launch = 1'h0;
        clr_flag = 1'h0;

        // settings land first so a start in the same write uses them
        if (wr_csr)
        begin
            nxt_st.csr.irq_en = wcsr.irq_en;
            nxt_st.csr.scan = wcsr.scan;
            nxt_st.csr.time_sel = wcsr.time_sel;
            nxt_st.csr.grp = wcsr.grp;
            nxt_st.csr.chan = wcsr.chan;
        end
        if (acc_tcr && bus_req.wr)
        begin
            nxt_st.trg_en = bus_req.wdata[`ADSQ_TCR_EN];
        end

        // a start while already running is not a restart
        if (!st_ff.csr.start)
        begin
            launch = (wr_csr && wcsr.start)
                || (trg_fall && st_ff.trg_en);
        end

        unique case (st_ff.seq)
            adsq_pkg::ADSQ_SEQ_IDLE:
            begin
                if (launch)
                begin
                    nxt_st.csr.start = 1'h1;
                    nxt_st.seq = adsq_pkg::ADSQ_SEQ_ISSUE;
                    if (nxt_st.csr.scan)
                    begin
                        nxt_st.cur_off = 2'h0;
                    end
                    else
                    begin
                        nxt_st.cur_off = nxt_st.csr.chan;
                    end
                end
            end
            adsq_pkg::ADSQ_SEQ_ISSUE:
            begin
                nxt_st.seq = adsq_pkg::ADSQ_SEQ_WAIT;
            end
            adsq_pkg::ADSQ_SEQ_WAIT:
            begin
                if (core_rsp.done)
                begin
                    res_wr = 1'h1;
                    if (!st_ff.csr.scan)
                    begin
                        set_flag = 1'h1;
                        nxt_st.csr.start = 1'h0;
                        nxt_st.seq = adsq_pkg::ADSQ_SEQ_IDLE;
                    end
                    else if (st_ff.cur_off == st_ff.csr.chan)
                    begin
                        set_flag = 1'h1;
                        nxt_st.cur_off = 2'h0;
                        nxt_st.seq = adsq_pkg::ADSQ_SEQ_ISSUE;
                    end
                    else
                    begin
                        nxt_st.cur_off = st_ff.cur_off + 2'h1;
                        nxt_st.seq = adsq_pkg::ADSQ_SEQ_ISSUE;
                    end
                end
            end
        endcase

        // software halt wins over the sequencer
        if (wr_csr && !wcsr.start)
        begin
            nxt_st.csr.start = 1'h0;
            nxt_st.seq = adsq_pkg::ADSQ_SEQ_IDLE;
        end

        // end flag: read as one arms the clear by a written zero
        if (acc_csr && bus_req.rd && st_ff.csr.end_flag)
        begin
            nxt_st.flag_seen = 1'h1;
        end
        if (wr_csr && !wcsr.end_flag && st_ff.flag_seen)
        begin
            clr_flag = 1'h1;
        end
        // only a real strobe counts as a dma access, not a bare select
        if (bus_req.dma && (bus_req.rd || bus_req.wr)
            && (acc_res || acc_csr || acc_tcr))
        begin
            clr_flag = 1'h1;
        end
        if (clr_flag)
        begin
            nxt_st.csr.end_flag = 1'h0;
            nxt_st.flag_seen = 1'h0;
        end
        // a completion in the clearing cycle is kept
        if (set_flag)
        begin
            nxt_st.csr.end_flag = 1'h1;
            nxt_st.flag_seen = 1'h0;
        end

        if (bus_req.sel && bus_req.rd)
        begin
            nxt_st.rdata = rd_mux;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!reset_n || standby)
        begin
            st_ff.csr <= CSR_RST;
            st_ff.trg_en <= TCR_RST[`ADSQ_TCR_EN];
            st_ff.flag_seen <= 1'h0;
            st_ff.seq <= adsq_pkg::ADSQ_SEQ_IDLE;
            st_ff.cur_off <= 2'h0;
            st_ff.rdata <= 8'h00;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign bus_rdata = st_ff.rdata;
    assign conv_done_irq = st_ff.csr.end_flag && st_ff.csr.irq_en;
    assign core_req.start = st_ff.seq == adsq_pkg::ADSQ_SEQ_ISSUE;
    assign core_req.channel = {st_ff.csr.grp, st_ff.cur_off};
    assign core_req.states = st_ff.csr.time_sel
        ? `ADSQ_STATES_FAST : `ADSQ_STATES_SLOW;

endmodule

`default_nettype wire

//--- test/adsq_ctl_chk.sv
`timescale 1ns/100ps
`default_nettype none
`include "adsq_params.svh"

module adsq_ctl_chk (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic standby,
    // register bus and pin
    input wire adsq_pkg::adsq_bus_req_s bus_req,
    input wire logic [7:0] bus_rdata,
    input wire logic ext_trigger_pin_n,
    // core and interrupt
    input wire adsq_pkg::adsq_core_req_s core_req,
    input wire adsq_pkg::adsq_core_rsp_s core_rsp,
    input wire logic conv_done_irq
);
// ----------------------------------------
// port relations
// ----------------------------------------
default clocking @(posedge core_clk); endclocking
default disable iff (!reset_n);
logic rd_ok;
assign rd_ok = bus_req.sel && bus_req.rd;

AST_RST_CLEAR: assert property ($rose(reset_n) |->
    bus_rdata == 8'h00 && !conv_done_irq && !core_req.start)
    else $error("state not clear after reset");
AST_STBY_CLEAR: assert property (standby |=>
    bus_rdata == 8'h00 && !conv_done_irq && !core_req.start)
    else $error("state not clear after standby");
AST_TCR_ONES: assert property (
    rd_ok && bus_req.addr == `ADSQ_OFS_TCR |=> bus_rdata[6:0] == 7'h7F)
    else $error("trigger register low bits not ones");
AST_LO_PAD: assert property (rd_ok && bus_req.addr[0] &&
    bus_req.addr <= `ADSQ_OFS_RES_LAST |=> bus_rdata[5:0] == 6'h00)
    else $error("result low byte padding not zero");
// done or dma in the read cycle may move the flag after the snapshot
AST_IRQ_FLAG: assert property (rd_ok && !bus_req.wr &&
    bus_req.addr == `ADSQ_OFS_CSR && !bus_req.dma && !core_rsp.done &&
    !standby |=> conv_done_irq == (bus_rdata[7] && bus_rdata[6]))
    else $error("irq differs from flag and enable");
AST_DMA_CLR: assert property (rd_ok && bus_req.dma &&
    bus_req.addr <= `ADSQ_OFS_TCR && !core_rsp.done |=> !conv_done_irq)
    else $error("dma access left irq up");
AST_START_PULSE: assert property (core_req.start |=> !core_req.start)
    else $error("core start longer than one cycle");
AST_CHAN_HOLD: assert property (
    core_req.start |=> $stable(core_req.channel) [*4])
    else $error("channel moved during conversion");
AST_BUDGET: assert property (core_req.start |->
    core_req.states inside {`ADSQ_STATES_SLOW, `ADSQ_STATES_FAST})
    else $error("conversion budget out of set");
endmodule

bind adsq_ctl adsq_ctl_chk u_chk (.core_clk(core_clk), .reset_n(reset_n),
    .standby(standby), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .ext_trigger_pin_n(ext_trigger_pin_n), .core_req(core_req),
    .core_rsp(core_rsp), .conv_done_irq(conv_done_irq));
`default_nettype wire

//--- test/adsq_core_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "adsq_params.svh"

module adsq_core_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // conversion request and value to report
    input wire adsq_pkg::adsq_core_req_s req,
    input wire logic [`ADSQ_RES_W-1:0] val,
    output adsq_pkg::adsq_core_rsp_s rsp
);
// ----------------------------------------
// behavioural converter
// ----------------------------------------
// latency follows the budget, so slow and fast answers both occur
logic [4:0] cnt_ff;
always_ff @(posedge core_clk)
begin
    if (!reset_n)
        cnt_ff <= 5'h00;
    else if (req.start)
        cnt_ff <= {1'b0, req.states[3:0]} + 5'h02;
    else if (cnt_ff != 5'h00)
        cnt_ff <= cnt_ff - 5'h01;
end
// result carries garbage outside the done pulse
assign rsp.done = (cnt_ff == 5'h01);
assign rsp.result = rsp.done ? val : ~val;
endmodule
`default_nettype wire

//--- test/adsq_ctl_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "adsq_params.svh"

module adsq_ctl_tb;
logic core_clk = 1'b0;
logic reset_n = 1'b0;
logic standby = 1'b0;
logic ext_trigger_pin_n = 1'b1;
adsq_pkg::adsq_bus_req_s bus_req = '0;
adsq_pkg::adsq_core_req_s core_req;
adsq_pkg::adsq_core_rsp_s core_rsp;
logic [7:0] bus_rdata;
logic conv_done_irq;
logic [9:0] res_val = 10'h000;
logic [7:0] cfg;
logic [7:0] exp_q[$];
logic [11:0] core_q[$];
logic rd_pend = 1'b0;
int fails = 0;
int samples_checked = 0;
int cycles = 0;
int seed = 17;
int i;

always #25 core_clk = ~core_clk;

adsq_ctl dut (.core_clk(core_clk), .reset_n(reset_n), .standby(standby),
    .bus_req(bus_req), .bus_rdata(bus_rdata),
    .ext_trigger_pin_n(ext_trigger_pin_n), .core_req(core_req),
    .core_rsp(core_rsp), .conv_done_irq(conv_done_irq));
adsq_core_model core (.core_clk(core_clk), .reset_n(reset_n),
    .req(core_req), .val(res_val), .rsp(core_rsp));
// ----------------------------------------
// tasks
// ----------------------------------------
task automatic end_sim;
    if (fails == 0 && samples_checked > 0)
        $display("STATUS OK");
    else
        $display("STATUS NOT OK");
    $finish;
endtask
task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
        fails++;
        $display("[ERR] %s expected %h seen %h", n, e, g);
    end
endtask
// channel and budget handed to the core at each start pulse
task automatic chk_core(input logic [11:0] e);
    samples_checked++;
    if ({core_req.channel, core_req.states} !== e)
    begin
        fails++;
        $display("[ERR] core_req expected %h seen %h", e,
            {core_req.channel, core_req.states});
    end
endtask
task automatic chk_irq(input logic e);
    cmp("conv_done_irq", {7'h00, e}, {7'h00, conv_done_irq});
endtask
task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge core_clk);
    bus_req = '{1'b1, 1'b0, 1'b1, 1'b0, a, d};
    @(negedge core_clk);
    bus_req = '0;
endtask
// expected byte is queued; the monitor pairs it with the answer
task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic dm);
    exp_q.push_back(e);
    @(negedge core_clk);
    bus_req = '{1'b1, 1'b1, 1'b0, dm, a, 8'h00};
    @(negedge core_clk);
    bus_req = '0;
endtask
task automatic wirq;
    int n;
    n = 0;
    while (conv_done_irq !== 1'b1 && n < 1000)
    begin
        @(negedge core_clk);
        n++;
    end
endtask
// ----------------------------------------
// monitor and timeout
// ----------------------------------------
always @(posedge core_clk)
begin
    cycles++;
    rd_pend <= bus_req.sel && bus_req.rd;
    if (cycles == 20000)
    begin
        fails++;
        end_sim();
    end
end
always @(negedge core_clk)
begin
    if (rd_pend && exp_q.size() > 0)
        cmp("bus_rdata", exp_q.pop_front(), bus_rdata);
    if (core_req.start === 1'b1 && core_q.size() > 0)
        chk_core(core_q.pop_front());
end
// ----------------------------------------
// main sequence
// ----------------------------------------
initial
begin
    repeat (4) @(negedge core_clk);
    reset_n = 1'b1;
    rd(4'h8, 8'h00, 1'b0);
    rd(4'h9, 8'h7F, 1'b0);
    rd(4'h0, 8'h00, 1'b0);
    rd(4'hD, 8'h00, 1'b0);
    wr(4'h9, 8'h00);
    rd(4'h9, 8'h7F, 1'b0);
    for (i = 0; i < 8; i++)
    begin
        res_val = 10'($random(seed));
        cfg = {4'h4, 1'($random(seed)), 3'(i)};
        core_q.push_back({cfg[2:0], (cfg[3] ? `ADSQ_STATES_FAST
            : `ADSQ_STATES_SLOW)});
        wr(4'h8, cfg | 8'h20);
        wirq();
        chk_irq(1'b1);
        // a zero written before any read must not clear the flag
        wr(4'h8, cfg & 8'hBF);
        chk_irq(1'b0);
        rd(4'h8, (cfg & 8'hBF) | 8'h80, 1'b0);
        rd(4'(i % 4 * 2), res_val[9:2], 1'b0);
        rd(4'(i % 4 * 2 + 1), {res_val[1:0], 6'h00}, 1'b0);
        wr(4'h8, cfg | 8'h80);
        chk_irq(1'b1);
        rd(4'h8, cfg | 8'h80, 1'b0);
        wr(4'h8, cfg);
        rd(4'h8, cfg, 1'b0);
        chk_irq(1'b0);
    end
    res_val = 10'h2B5;
    for (i = 0; i < 3; i++)
        core_q.push_back({1'b0, 2'(i), `ADSQ_STATES_SLOW});
    wr(4'h8, 8'h72);
    wirq();
    chk_irq(1'b1);
    rd(4'h8, 8'hF2, 1'b0);
    rd(4'h4, res_val[9:2], 1'b1);
    rd(4'h8, 8'h72, 1'b0);
    wr(4'h8, 8'h40);
    rd(4'h8, 8'h40, 1'b0);
    res_val = 10'($random(seed));
    wr(4'h9, 8'h80);
    rd(4'h9, 8'hFF, 1'b0);
    wr(4'h8, 8'h45);
    core_q.push_back({3'h5, `ADSQ_STATES_SLOW});
    @(negedge core_clk);
    ext_trigger_pin_n = 1'b0;
    wirq();
    ext_trigger_pin_n = 1'b1;
    chk_irq(1'b1);
    rd(4'h8, 8'hC5, 1'b0);
    rd(4'h2, res_val[9:2], 1'b0);
    wr(4'h8, 8'h45);
    wr(4'h9, 8'h00);
    @(negedge core_clk);
    ext_trigger_pin_n = 1'b0;
    repeat (30) @(negedge core_clk);
    ext_trigger_pin_n = 1'b1;
    rd(4'h8, 8'h45, 1'b0);
    wr(4'h9, 8'h80);
    @(negedge core_clk);
    standby = 1'b1;
    @(negedge core_clk);
    standby = 1'b0;
    rd(4'h8, 8'h00, 1'b0);
    rd(4'h9, 8'h7F, 1'b0);
    rd(4'h2, 8'h00, 1'b0);
    cmp("core_starts_missing", 8'h00, 8'(core_q.size()));
    end_sim();
end
endmodule
`default_nettype wire
